// ===== include/pms_defines.vh
// Register map, field positions and reset values of the power mode sequencer
`ifndef PMS_DEFINES_VH
`define PMS_DEFINES_VH

`define PMS_ADDR_W             4
`define PMS_DATA_W             8

`define PMS_ADDR_PWR_FIRST     4'h0
`define PMS_ADDR_PWR_SECOND    4'h1
`define PMS_ADDR_REG_CTRL      4'h2
`define PMS_ADDR_CLK_CTRL      4'h3
`define PMS_ADDR_PERIPH_GATE   4'h4
`define PMS_ADDR_TMR_CLK       4'h5
`define PMS_ADDR_MODE_STAT     4'h6
`define PMS_ADDR_WAKE_CAUSE    4'h7

`define PMS_BIT_IDLE           0
`define PMS_BIT_STOP           1
`define PMS_BIT_SUSPEND        0
`define PMS_BIT_SNOOZE         1
`define PMS_BIT_LDO_OFF        0
`define PMS_BIT_VREG5_EN       1

`define PMS_CLK_SRC_LSB        0
`define PMS_CLK_SRC_MSB        1
`define PMS_CLK_DIV_LSB        2
`define PMS_CLK_DIV_MSB        4
`define PMS_CLK_PRESCALE       5

`define PMS_SRC_FAST_24M       2'h0
`define PMS_SRC_FAST_49M       2'h1
`define PMS_SRC_EXT            2'h2
`define PMS_SRC_SLOW           2'h3

`define PMS_RST_CLK_SRC        2'h0
`define PMS_RST_CLK_DIV        3'h3
`define PMS_RST_PERIPH_GATE    8'h00
`define PMS_RST_REG_CTRL       2'h0
`define PMS_RST_TMR_CLK        2'h0

`define PMS_SLOW_TMR_DIV       3'h3
`define PMS_NUM_WAKE           5

`endif

// ===== hdl/pms_clk_div.v
// Tick divider: optional 1.5x prescale followed by a power-of-two divider
`timescale 1ns/100ps
`default_nettype none

module pms_clk_div #(
  parameter CNT_W = 7
) (
  input  wire             clk,
  input  wire             srst,
  input  wire             in_tick,
  input  wire             prescale,
  input  wire [2:0]       div_sel,
  output reg              out_tick
);

  reg  [1:0]       pre_cnt;
  reg  [CNT_W-1:0] cnt;
  wire             pre_pass;
  wire [CNT_W-1:0] mask;

  // Two of every three input ticks pass, giving divide by 1.5
  assign pre_pass = in_tick & (~prescale | (pre_cnt != 2'h2));
  assign mask     = ({CNT_W{1'b1}} >> (CNT_W - div_sel)) & {CNT_W{1'b1}};

  always @(posedge clk) begin
    if (srst) begin
      pre_cnt  <= 2'h0;
      cnt      <= {CNT_W{1'b0}};
      out_tick <= 1'b0;
    end else begin
      if (in_tick) begin
        pre_cnt <= (pre_cnt == 2'h2) ? 2'h0 : pre_cnt + 2'h1;
      end
      if (pre_pass) begin
        cnt <= cnt + {{(CNT_W-1){1'b0}}, 1'b1};
      end
      out_tick <= pre_pass & ((cnt & mask) == mask);
    end
  end

endmodule // pms_clk_div

`default_nettype wire

// ===== hdl/pms_top.v
// Power mode sequencer: mode state machine, clock and regulator controls
`timescale 1ns/100ps
`default_nettype none
`include "pms_defines.vh"

// Contract
// [RULE_01] Normal mode keeps core and all peripherals clocked. Code clocks only peripherals set in periph_gate (reset 0).
// [RULE_02] Idle bit halts core, peripherals stay clocked; any interrupt resumes.
// [RULE_03] Software selects the 24.5 MHz source before setting suspend.
// [RULE_04] Suspend halts clocks, stops both fast oscillators, regulators normal bias.
// [RULE_05] Software selects the 24.5 MHz source before setting snooze.
// [RULE_06] Snooze halts clocks, stops fast oscillators, regulators in low bias.
// [RULE_07] Suspend and snooze wake on timer 4, SPI, I2C, port match, comparator fall.
// [RULE_08] Timers 3 and 4 may count slow oscillator divided by 8.
// [RULE_09] Software clears the LDO-off flag, then sets stop, for stop mode.
// [RULE_10] Stop cuts power nets, keeps core LDO, holds pins, exits on reset.
// [RULE_11] LDO-off flag then stop enters shutdown with the core LDO off.
// [RULE_12] Shutdown exits only on reset pin or power-on reset.
// [RULE_13] The 5 V regulator stays on in stop and shutdown if enabled.
// [RULE_14] After reset the clock is 24.5 MHz source divided by 8.
// [RULE_15] Divider offers powers of two from 1 through 128.
// [RULE_16] Fast oscillators offer an optional 1.5x prescaler.
// [RULE_17] Unused digital peripherals have their clocks gated off.
// [RULE_18] Mode request bits read back cleared after wake.
module pms_top #(
  parameter PERIPH_N = 8
) (
  input  wire                   clk,
  input  wire                   srst,
  input  wire [`PMS_ADDR_W-1:0] reg_addr,
  input  wire [`PMS_DATA_W-1:0] reg_wdata,
  input  wire                   reg_wr,
  input  wire                   reg_rd,
  output reg  [`PMS_DATA_W-1:0] reg_rdata,
  input  wire                   irq_any,
  input  wire                   other_reset,
  input  wire                   reset_pin_n,
  input  wire                   power_on_reset,
  input  wire                   timer4_event,
  input  wire                   serial_periph_port_act,
  input  wire                   two_wire_slave_port_act,
  input  wire                   port_match,
  input  wire                   cmp0_out,
  input  wire                   slow_osc_80k,
  output wire                   core_clk_en,
  output wire [PERIPH_N-1:0]    periph_clk_en,
  output wire                   fast_osc_24m_en,
  output wire                   fast_osc_49m_en,
  output wire                   slow_osc_80k_en,
  output wire                   reg_low_bias,
  output wire                   core_ldo_en,
  output wire                   vreg5_en,
  output wire                   power_nets_en,
  output wire                   pin_hold,
  output reg                    sys_reset_req,
  output wire [1:0]             clk_src_sel,
  output wire                   system_clock_tick,
  output wire                   timer3_slow_tick,
  output wire                   timer4_slow_tick
);

  localparam [5:0] ST_NORMAL   = 6'h01;
  localparam [5:0] ST_IDLE     = 6'h02;
  localparam [5:0] ST_SUSPEND  = 6'h04;
  localparam [5:0] ST_SNOOZE   = 6'h08;
  localparam [5:0] ST_STOP     = 6'h10;
  localparam [5:0] ST_SHUTDOWN = 6'h20;

  localparam SYNC_N = 8;

  reg  [5:0]          state;
  reg  [5:0]          next_state;
  reg  [1:0]          clk_src;
  reg  [2:0]          clk_div;
  reg                 clk_prescale;
  reg  [PERIPH_N-1:0] periph_gate;
  reg                 ldo_off_flag;
  reg                 vreg5_enable;
  reg  [1:0]          tmr_slow_sel;
  reg  [`PMS_NUM_WAKE-1:0] wake_cause;
  reg  [SYNC_N-1:0]   sync_a;
  reg  [SYNC_N-1:0]   sync_b;
  reg                 cmp0_prev;
  reg                 slow_prev;
  reg                 go_normal;

  wire [SYNC_N-1:0]   async_in;
  wire                pin_rst;
  wire                por_rst;
  wire                cmp0_fall;
  wire                slow_edge;
  wire [`PMS_NUM_WAKE-1:0] wake_vec;
  wire                wake_any;
  wire                in_active;
  wire                in_low_clk;
  wire                in_off;
  wire                wr_first;
  wire                wr_second;
  wire                req_idle;
  wire                req_stop;
  wire                req_suspend;
  wire                req_snooze;
  wire                src_ok;
  wire                slow_tmr_tick;

  // Pins and foreign clocks cross through two flops first
  assign async_in = {slow_osc_80k, cmp0_out, port_match, two_wire_slave_port_act,
                     serial_periph_port_act, timer4_event, power_on_reset, ~reset_pin_n};

  genvar gi;
  generate
    for (gi = 0; gi < SYNC_N; gi = gi + 1) begin : g_sync
      always @(posedge clk) begin
        if (srst) begin
          sync_a[gi] <= 1'b0;
          sync_b[gi] <= 1'b0;
        end else begin
          sync_a[gi] <= async_in[gi];
          sync_b[gi] <= sync_a[gi];
        end
      end
    end
  endgenerate

  always @(posedge clk) begin
    if (srst) begin
      cmp0_prev <= 1'b0;
      slow_prev <= 1'b0;
    end else begin
      cmp0_prev <= sync_b[6];
      slow_prev <= sync_b[7];
    end
  end

  assign pin_rst   = sync_b[0];
  assign por_rst   = sync_b[1];
  assign cmp0_fall = cmp0_prev & ~sync_b[6];
  assign slow_edge = sync_b[7] & ~slow_prev;

  // [RULE_07] Low power wake sources
  assign wake_vec = {cmp0_fall, sync_b[5], sync_b[4], sync_b[3], sync_b[2]};
  assign wake_any = |wake_vec;

  assign in_active  = (state == ST_NORMAL) | (state == ST_IDLE);
  assign in_low_clk = (state == ST_SUSPEND) | (state == ST_SNOOZE);
  assign in_off     = (state == ST_STOP) | (state == ST_SHUTDOWN);

  assign wr_first  = reg_wr & (reg_addr == `PMS_ADDR_PWR_FIRST);
  assign wr_second = reg_wr & (reg_addr == `PMS_ADDR_PWR_SECOND);

  assign req_idle    = wr_first & reg_wdata[`PMS_BIT_IDLE];
  assign req_stop    = wr_first & reg_wdata[`PMS_BIT_STOP];
  assign req_suspend = wr_second & reg_wdata[`PMS_BIT_SUSPEND];
  assign req_snooze  = wr_second & reg_wdata[`PMS_BIT_SNOOZE];

  // [RULE_03] Entry refused unless on the 24.5 MHz source
  // [RULE_05] Same guard for snooze entry
  assign src_ok = (clk_src == `PMS_SRC_FAST_24M);

  // Mode state machine; deeper modes win when several bits are set at once
  always @* begin
    next_state = state;
    go_normal  = 1'b0;
    case (state)
      ST_NORMAL: begin
        if (req_stop) begin
          // [RULE_09] Flag clear selects stop
          // [RULE_11] Flag set selects shutdown
          next_state = ldo_off_flag ? ST_SHUTDOWN : ST_STOP;
        end else if (req_snooze & src_ok) begin
          next_state = ST_SNOOZE;
        end else if (req_suspend & src_ok) begin
          next_state = ST_SUSPEND;
        end else if (req_idle) begin
          next_state = ST_IDLE;
        end
      end
      ST_IDLE: begin
        // [RULE_02] Any interrupt resumes
        if (irq_any | wake_any) begin
          next_state = ST_NORMAL;
        end
      end
      ST_SUSPEND, ST_SNOOZE: begin
        // [RULE_07] Resume on wake event
        if (wake_any) begin
          next_state = ST_NORMAL;
        end
      end
      ST_STOP: begin
        // [RULE_10] Any reset source leaves stop
        if (pin_rst | por_rst | other_reset) begin
          next_state = ST_NORMAL;
          go_normal  = 1'b1;
        end
      end
      ST_SHUTDOWN: begin
        // [RULE_12] Only pin or power-on reset
        if (pin_rst | por_rst) begin
          next_state = ST_NORMAL;
          go_normal  = 1'b1;
        end
      end
      default: begin
        next_state = ST_NORMAL;
      end
    endcase
  end

  always @(posedge clk) begin
    if (srst) begin
      state         <= ST_NORMAL;
      sys_reset_req <= 1'b0;
      wake_cause    <= {`PMS_NUM_WAKE{1'b0}};
    end else begin
      state         <= next_state;
      sys_reset_req <= go_normal;
      // Cause kept for software after a low power wake
      if (in_low_clk & wake_any) begin
        wake_cause <= wake_vec;
      end
    end
  end

  // Software settings; a reset from stop also restores defaults
  always @(posedge clk) begin
    if (srst | go_normal) begin
      // [RULE_14] Default 24.5 MHz divided by 8
      clk_src      <= `PMS_RST_CLK_SRC;
      clk_div      <= `PMS_RST_CLK_DIV;
      clk_prescale <= 1'b0;
      periph_gate  <= `PMS_RST_PERIPH_GATE;
      tmr_slow_sel <= `PMS_RST_TMR_CLK;
    end else if (reg_wr & (state == ST_NORMAL)) begin
      case (reg_addr)
        `PMS_ADDR_CLK_CTRL: begin
          clk_src      <= reg_wdata[`PMS_CLK_SRC_MSB:`PMS_CLK_SRC_LSB];
          clk_div      <= reg_wdata[`PMS_CLK_DIV_MSB:`PMS_CLK_DIV_LSB];
          clk_prescale <= reg_wdata[`PMS_CLK_PRESCALE];
        end
        `PMS_ADDR_PERIPH_GATE: begin
          periph_gate <= reg_wdata[PERIPH_N-1:0];
        end
        `PMS_ADDR_TMR_CLK: begin
          tmr_slow_sel <= reg_wdata[1:0];
        end
        default: begin
          periph_gate <= periph_gate;
        end
      endcase
    end
  end

  // Regulator bits survive a stop exit so the 5 V supply is not dropped
  always @(posedge clk) begin
    if (srst) begin
      ldo_off_flag <= 1'b0;
      vreg5_enable <= 1'b0;
    end else if (reg_wr & (reg_addr == `PMS_ADDR_REG_CTRL) & (state == ST_NORMAL)) begin
      ldo_off_flag <= reg_wdata[`PMS_BIT_LDO_OFF];
      vreg5_enable <= reg_wdata[`PMS_BIT_VREG5_EN];
    end
  end

  // Register read port, data one cycle after the strobe
  always @(posedge clk) begin
    if (srst) begin
      reg_rdata <= {`PMS_DATA_W{1'b0}};
    end else if (reg_rd) begin
      case (reg_addr)
        `PMS_ADDR_PWR_FIRST: begin
          // [RULE_18] Bits reflect the live mode only
          reg_rdata <= {6'h00, in_off, state == ST_IDLE};
        end
        `PMS_ADDR_PWR_SECOND: begin
          reg_rdata <= {6'h00, state == ST_SNOOZE, state == ST_SUSPEND};
        end
        `PMS_ADDR_REG_CTRL: begin
          reg_rdata <= {6'h00, vreg5_enable, ldo_off_flag};
        end
        `PMS_ADDR_CLK_CTRL: begin
          reg_rdata <= {2'h0, clk_prescale, clk_div, clk_src};
        end
        `PMS_ADDR_PERIPH_GATE: begin
          reg_rdata <= periph_gate;
        end
        `PMS_ADDR_TMR_CLK: begin
          reg_rdata <= {6'h00, tmr_slow_sel};
        end
        `PMS_ADDR_MODE_STAT: begin
          reg_rdata <= {2'h0, state};
        end
        `PMS_ADDR_WAKE_CAUSE: begin
          reg_rdata <= {3'h0, wake_cause};
        end
        default: begin
          reg_rdata <= {`PMS_DATA_W{1'b0}};
        end
      endcase
    end else begin
      reg_rdata <= {`PMS_DATA_W{1'b0}};
    end
  end

  // [RULE_01] Core runs only in normal
  assign core_clk_en = (state == ST_NORMAL);

  // [RULE_17] Gate unused peripherals
  assign periph_clk_en = in_active ? periph_gate : {PERIPH_N{1'b0}};

  // [RULE_04] Fast oscillators stop outside active modes
  assign fast_osc_24m_en = in_active;
  assign fast_osc_49m_en = in_active & (clk_src == `PMS_SRC_FAST_49M);
  assign slow_osc_80k_en = ~in_off;

  // [RULE_06] Low bias only in snooze
  assign reg_low_bias = (state == ST_SNOOZE);

  // [RULE_10] Power nets off, pins held
  assign power_nets_en = ~in_off;
  assign pin_hold      = in_off;

  // [RULE_11] Core LDO off in shutdown
  assign core_ldo_en = (state != ST_SHUTDOWN);

  // [RULE_13] 5 V regulator follows its enable
  assign vreg5_en = vreg5_enable;

  assign clk_src_sel = clk_src;

  // [RULE_15] Power-of-two system divider
  // [RULE_16] Prescale only on the fast sources
  pms_clk_div #(
    .CNT_W    (7)
  ) u_sys_div (
    .clk      (clk),
    .srst     (srst),
    .in_tick  (1'b1),
    .prescale (clk_prescale & ~clk_src[1]),
    .div_sel  (clk_div),
    .out_tick (system_clock_tick)
  );

  // [RULE_08] Slow oscillator divided by 8 for timers
  pms_clk_div #(
    .CNT_W    (7)
  ) u_tmr_div (
    .clk      (clk),
    .srst     (srst),
    .in_tick  (slow_edge),
    .prescale (1'b0),
    .div_sel  (`PMS_SLOW_TMR_DIV),
    .out_tick (slow_tmr_tick)
  );

  // Not available once power nets are down
  assign timer3_slow_tick = slow_tmr_tick & tmr_slow_sel[0] & ~in_off;
  assign timer4_slow_tick = slow_tmr_tick & tmr_slow_sel[1] & ~in_off;

endmodule // pms_top

`default_nettype wire

// ===== tb/pms_checker.sv
// Concurrent checks on the power mode sequencer ports
`timescale 1ns/100ps
`default_nettype none
module pms_checker #(
  parameter PERIPH_N = 8
) (
  input wire logic                clk,
  input wire logic                srst,
  input wire logic [3:0]          reg_addr,
  input wire logic [7:0]          reg_wdata,
  input wire logic                reg_wr,
  input wire logic                irq_any,
  input wire logic                reset_pin_n,
  input wire logic                power_on_reset,
  input wire logic                timer4_event,
  input wire logic                core_clk_en,
  input wire logic [PERIPH_N-1:0] periph_clk_en,
  input wire logic                fast_osc_24m_en,
  input wire logic                reg_low_bias,
  input wire logic                core_ldo_en,
  input wire logic                power_nets_en,
  input wire logic                pin_hold,
  input wire logic                sys_reset_req,
  input wire logic [1:0]          clk_src_sel
);
  // Four quiet samples cover the reset synchroniser delay
  logic [3:0] quiet;
  always_ff @(posedge clk)
    if (srst) quiet <= 4'h0;
    else quiet <= {quiet[2:0], reset_pin_n && !power_on_reset};

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  idle_entry_a:
    assert property (reg_wr && reg_addr == 4'h0 && reg_wdata == 8'h01 && core_clk_en && !irq_any
      |=> !core_clk_en && fast_osc_24m_en) else $error("idle entry not taken");
  idle_wake_a:
    assert property (!core_clk_en && fast_osc_24m_en && irq_any |=> core_clk_en)
      else $error("idle did not wake");
  snooze_state_a:
    assert property (reg_low_bias |-> !core_clk_en && !fast_osc_24m_en && periph_clk_en == '0)
      else $error("snooze clocks running");
  sleep_wake_a:
    assert property (!core_clk_en && !fast_osc_24m_en && power_nets_en && timer4_event
      |-> ##[1:4] core_clk_en) else $error("timer wake missed");
  stop_power_a:
    assert property (pin_hold |-> !power_nets_en && !core_clk_en && periph_clk_en == '0)
      else $error("stop power nets on");
  stop_exit_a:
    assert property (sys_reset_req |-> $past(pin_hold) && core_clk_en ##1 !sys_reset_req)
      else $error("bad stop exit pulse");
  shutdown_hold_a:
    assert property (!core_ldo_en && quiet == 4'hF |=> !core_ldo_en)
      else $error("shutdown left without reset");
  reset_clock_a:
    assert property ($fell(srst) |-> clk_src_sel == 2'h0 && core_clk_en && core_ldo_en)
      else $error("bad state after reset");
endmodule // pms_checker

bind pms_top pms_checker #(.PERIPH_N(PERIPH_N)) u_pms_checker (
  .clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .irq_any(irq_any), .reset_pin_n(reset_pin_n), .power_on_reset(power_on_reset),
  .timer4_event(timer4_event), .core_clk_en(core_clk_en), .periph_clk_en(periph_clk_en),
  .fast_osc_24m_en(fast_osc_24m_en), .reg_low_bias(reg_low_bias), .core_ldo_en(core_ldo_en),
  .power_nets_en(power_nets_en), .pin_hold(pin_hold), .sys_reset_req(sys_reset_req),
  .clk_src_sel(clk_src_sel)
);
`default_nettype wire

// ===== tb/pms_partner.sv
// Wake event and reset sources around the sequencer
`timescale 1ns/100ps
`default_nettype none
module pms_partner (
  input  wire logic       clk,
  input  wire logic       req,
  input  wire logic [2:0] kind,
  output var  logic [7:0] line,
  output var  logic       slow_osc_80k
);
  logic [3:0] hold;
  logic [1:0] phase;
  initial begin
    line = 8'h00;
    hold = 4'h0;
    phase = 2'h0;
    slow_osc_80k = 1'b0;
  end
  // Held events
  // Held eleven cycles so async synchronisers never miss one
  always @(posedge clk) begin
    phase <= phase + 2'h1;
    if (phase == 2'h3) slow_osc_80k <= !slow_osc_80k;
    if (req) begin
      line <= 8'h01 << kind;
      hold <= 4'hA;
    end else if (hold != 4'h0) hold <= hold - 4'h1;
    else line <= 8'h00;
  end
endmodule // pms_partner
`default_nettype wire

// ===== tb/tb_top.sv
// Self-checking bench for the power mode sequencer
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic irq_any = 1'b0;
  logic req = 1'b0;
  logic [2:0] kind = 3'h0;
  wire [7:0] reg_rdata, periph_clk_en, line;
  wire [1:0] clk_src_sel;
  wire core_clk_en, fast_osc_24m_en, fast_osc_49m_en, slow_osc_80k_en, reg_low_bias, core_ldo_en;
  wire vreg5_en, power_nets_en, pin_hold, sys_reset_req, system_clock_tick, t3, t4, slow;
  wire [7:0] st = {core_clk_en, fast_osc_24m_en, fast_osc_49m_en, slow_osc_80k_en,
                   reg_low_bias, core_ldo_en, power_nets_en, pin_hold};
  int miscompares = 0;
  int comparisons = 0;
  int n, c, m, k, a, b;
  always #2.5 clk = !clk;

  pms_partner u_pms_partner (.clk(clk), .req(req), .kind(kind), .line(line), .slow_osc_80k(slow));
  pms_top u_pms_top (
    .clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq_any(irq_any), .other_reset(line[7]),
    .reset_pin_n(!line[5]), .power_on_reset(line[6]), .timer4_event(line[0]),
    .serial_periph_port_act(line[1]), .two_wire_slave_port_act(line[2]), .port_match(line[3]),
    .cmp0_out(!line[4]), .slow_osc_80k(slow), .core_clk_en(core_clk_en),
    .periph_clk_en(periph_clk_en), .fast_osc_24m_en(fast_osc_24m_en),
    .fast_osc_49m_en(fast_osc_49m_en), .slow_osc_80k_en(slow_osc_80k_en),
    .reg_low_bias(reg_low_bias), .core_ldo_en(core_ldo_en), .vreg5_en(vreg5_en),
    .power_nets_en(power_nets_en), .pin_hold(pin_hold), .sys_reset_req(sys_reset_req),
    .clk_src_sel(clk_src_sel), .system_clock_tick(system_clock_tick),
    .timer3_slow_tick(t3), .timer4_slow_tick(t4)
  );

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] ad, input logic [7:0] d);
    reg_addr <= ad;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [3:0] ad, input logic [7:0] e);
    reg_addr <= ad;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    chk(reg_rdata, e);
    @(posedge clk);
  endtask
  // Mode outputs, then 5 V regulator with the peripheral gates
  task automatic look(input logic [7:0] e, input logic [8:0] p);
    @(negedge clk);
    chk(st, e);
    chk({vreg5_en, periph_clk_en}, p);
    @(posedge clk);
  endtask
  task automatic fire(input logic [2:0] t);
    kind <= t;
    req <= 1'b1;
    @(posedge clk);
    req <= 1'b0;
  endtask
  task automatic wake(input logic r);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (core_clk_en !== 1'b1 && n < 20);
    chk({core_clk_en, sys_reset_req}, {1'b1, r});
    @(posedge clk);
  endtask
  task automatic close_out;
    if (miscompares == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge clk);
    miscompares++;
    close_out;
  end

  initial begin
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    look(8'hD6, 9'h000);
    rd(4'h3, 8'h0C);
    rd(4'h6, 8'h01);
    rd(4'hF, 8'h00);
    wr(4'h6, 8'hFF);
    rd(4'h6, 8'h01);
    wr(4'h4, 8'hA5);
    look(8'hD6, 9'h0A5);
    // Third pass: prescale bit on the external source must not apply
    for (m = 0; m < 3; m++) begin
      for (k = 0; k < 8; k++) begin
        wr(4'h3, 8'(32 * (m > 0) + 2 * (m == 2) + 4 * k));
        a = 0;
        c = 0;
        n = 0;
        while (a < 4 && n < 2000) begin
          @(negedge clk);
          n++;
          if (a > 1) c++;
          if (system_clock_tick === 1'b1) a++;
        end
        chk(16'(c), 16'((2 + (m == 1)) << k));
      end
    end
    wr(4'h3, 8'h0D);
    wr(4'h1, 8'h01);
    look(8'hF6, 9'h0A5);
    wr(4'h3, 8'h0C);
    wr(4'h0, 8'h01);
    look(8'h56, 9'h0A5);
    rd(4'h6, 8'h02);
    irq_any <= 1'b1;
    @(posedge clk);
    irq_any <= 1'b0;
    wake(1'b0);
    rd(4'h0, 8'h00);
    wr(4'h5, 8'h03);
    wr(4'h1, 8'h02);
    repeat (64) @(posedge clk);
    a = 0;
    b = 0;
    repeat (512) begin
      @(negedge clk);
      a += int'(t3 === 1'b1);
      b += int'(t4 === 1'b1);
    end
    chk(16'(a * 16 + b), 16'h0088);
    // Leave snooze before the sleep scenarios; let the event line settle
    @(posedge clk);
    fire(3'h0);
    wake(1'b0);
    repeat (12) @(posedge clk);
    for (m = 0; m < 2; m++) begin
      for (k = 0; k < 5; k++) begin
        @(posedge clk);
        wr(4'h1, m ? 8'h02 : 8'h01);
        look(m ? 8'h1E : 8'h16, 9'h000);
        rd(4'h6, m ? 8'h08 : 8'h04);
        fire(3'(k));
        wake(1'b0);
        rd(4'h1, 8'h00);
        rd(4'h7, 8'(1 << k));
        repeat (12) @(posedge clk);
      end
    end
    wr(4'h2, 8'h02);
    wr(4'h0, 8'h02);
    look(8'h05, 9'h100);
    fire(3'h0);
    repeat (20) @(posedge clk);
    look(8'h05, 9'h100);
    fire(3'h7);
    wake(1'b1);
    rd(4'h3, 8'h0C);
    rd(4'h2, 8'h02);
    for (k = 5; k < 7; k++) begin
      repeat (12) @(posedge clk);
      wr(4'h2, 8'h03);
      wr(4'h0, 8'h02);
      look(8'h01, 9'h100);
      fire(3'h7);
      repeat (12) @(posedge clk);
      fire(3'h0);
      repeat (12) @(posedge clk);
      look(8'h01, 9'h100);
      fire(3'(k));
      wake(1'b1);
    end
    close_out;
  end
endmodule // tb_top
`default_nettype wire
